/* verilog/pll_ctrl_pkg.sv */
package pll_ctrl_pkg;
    // word layout
    localparam int word_bits = 24; // serial word length
    localparam int ctrl_bits = 4; // address nibble width
    localparam logic [3:0] addr_main_divider = 4'h0; // main divider word address
    localparam logic [3:0] addr_aux_divider = 4'h2; // aux divider word address (its control nibble)
    localparam logic [3:0] addr_timeout = 4'h9; // if fastlock timeout word
    localparam logic [3:0] addr_mode = 4'hb; // mode and output select word
    // fields of the timeout word
    localparam int timeout_lsb = 4; // timeout field low bit
    localparam int timeout_bits = 12; // timeout field width
    // fields of the mode word
    localparam int mux_lsb = 4; // output selector low bit
    localparam int osc_lsb = 8; // differential select bit
    localparam int dbl_lsb = 9; // doubler enable bit
    localparam int auto_powerup_select_lsb = 10; // auto power-up low bit
    // fields of the slip reduction word (fourth word, address 7)
    localparam logic [3:0] addr_slip = 4'h7; // word that carries slip reduction
    localparam int slip_lsb = 22; // slip reduction field low bit
    // reset values
    localparam logic [11:0] timeout_reset = 12'h000; // pin high-z at reset
    localparam logic [3:0] mux_reset = 4'h0; // test pin high-z at reset
    localparam logic [1:0] slip_reset = 2'h0; // slip reduction off
    localparam logic [11:0] timeout_min_auto = 12'h004; // first automatic timeout
    // auto power-up codes
    localparam logic [1:0] auto_powerup_select_none = 2'h0;
    localparam logic [1:0] auto_powerup_select_rf = 2'h1;
    localparam logic [1:0] auto_powerup_select_both = 2'h2;
    // charge pump current codes
    localparam logic cp_gain_high = 1'b1; // 4 ma setting
    // serial receiver states
    typedef enum logic [1:0] {
        rx_idle = 2'b01,
        rx_shift = 2'b10
    } rx_state_type;
endpackage

/* verilog/sync_edge.sv */
// two-flop synchroniser with rise detect on the second stage copy
module sync_edge (
    clk,
    rst,
    async_in,
    level,
    rise
);
    input wire logic clk;
    input wire logic rst;
    input wire logic async_in;
    output logic level;
    output logic rise;
    logic meta_r; // first stage, read only by level
    logic level_r; // second stage
    logic prev_r; // delayed copy for edge detect
    logic meta_nxt;
    logic level_nxt;
    logic prev_nxt;
    // next values of the chain
    always_comb begin
        meta_nxt = async_in;
        level_nxt = meta_r;
        prev_nxt = level_r;
    end
    // register the chain
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= 1'b0;
            level_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            level_r <= level_nxt;
            prev_r <= prev_nxt;
        end
    end
    assign level = level_r;
    assign rise = level_r & ~prev_r;
endmodule

/* verilog/pll_fastlock_output_control.sv */
// Functional notes
// - slip code 0 off, else 1/2, 1/4, 1/16
// - timeout 0..3 disables aux fastlock
// - timeout 4..4095 enables fastlock output pin
// - fastlock lasts timeout comparison cycles
// - timeout 0 high-z, 2 low, 3 high
// - timeout 1: pin low, pump forced high
// - test pin code 0 high-z, 1..5 push-pull choices
// - codes 6..8 open drain, 9..11 push-pull analog
// - codes 12..15 divider outputs halved
// - ref mode bit selects single or differential
// - doubler off passes reference unchanged
// - auto power-up codes on main word write
// - aux divider word never auto powers up
module pll_fastlock_output_control (
    clk,
    rst,
    ser_clk,
    ser_data,
    ser_load,
    aux_comp_pulse,
    aux_lock_start,
    dig_lock_rf,
    dig_lock_if,
    ana_lock_rf,
    ana_lock_if,
    if_r_out,
    if_n_out,
    rf_r_out,
    rf_n_out,
    aux_fastlock_pin_o,
    aux_fastlock_pin_oe,
    aux_fastlock_active,
    test_lock_pin_o,
    test_lock_pin_oe,
    aux_pump_gain_force,
    slip_reduction_select,
    slip_reduction_shift,
    ref_differential_select,
    ref_doubler_enable,
    rf_powerup_pulse,
    if_powerup_pulse
);
    input wire logic clk;
    input wire logic rst;
    input wire logic ser_clk; // serial clock pin
    input wire logic ser_data; // serial data pin
    input wire logic ser_load; // load strobe pin
    input wire logic aux_comp_pulse; // one pulse per aux phase comparison, same domain
    input wire logic aux_lock_start; // pulse: start an aux fastlock period, same domain
    input wire logic dig_lock_rf;
    input wire logic dig_lock_if;
    input wire logic ana_lock_rf;
    input wire logic ana_lock_if;
    input wire logic if_r_out; // divider outputs, same domain
    input wire logic if_n_out;
    input wire logic rf_r_out;
    input wire logic rf_n_out;
    output logic aux_fastlock_pin_o;
    output logic aux_fastlock_pin_oe;
    output logic aux_fastlock_active; // aux loop in fastlock state
    output logic test_lock_pin_o;
    output logic test_lock_pin_oe;
    output logic aux_pump_gain_force; // force aux pump to high current
    output logic [1:0] slip_reduction_select;
    output logic [3:0] slip_reduction_shift; // log2 of sample rate divisor
    output logic ref_differential_select;
    output logic ref_doubler_enable;
    output logic rf_powerup_pulse;
    output logic if_powerup_pulse;

    // synchronised serial pins
    logic sclk_rise;
    logic sdata_lvl;
    logic load_lvl;
    logic load_rise;
    sync_edge u_sclk (.clk(clk), .rst(rst), .async_in(ser_clk), .level(), .rise(sclk_rise));
    sync_edge u_sdata (.clk(clk), .rst(rst), .async_in(ser_data), .level(sdata_lvl), .rise());
    sync_edge u_load (.clk(clk), .rst(rst), .async_in(ser_load), .level(load_lvl), .rise(load_rise));

    // receiver state
    pll_ctrl_pkg::rx_state_type rx_r, rx_nxt;
    logic [23:0] shift_r, shift_nxt; // incoming word
    // stored fields
    logic [11:0] timeout_r, timeout_nxt;
    logic [3:0] mux_r, mux_nxt;
    logic [1:0] auto_powerup_select_r, auto_powerup_select_nxt;
    logic osc_r, osc_nxt;
    logic dbl_r, dbl_nxt;
    logic [1:0] slip_r, slip_nxt;
    logic rfpu_r, rfpu_nxt;
    logic ifpu_r, ifpu_nxt;
    logic [3:0] addr; // control nibble of the shifted word

    assign addr = shift_r[3:0];

    // serial shift and word latch
    always_comb begin
        rx_nxt = rx_r;
        shift_nxt = shift_r;
        timeout_nxt = timeout_r;
        mux_nxt = mux_r;
        auto_powerup_select_nxt = auto_powerup_select_r;
        osc_nxt = osc_r;
        dbl_nxt = dbl_r;
        slip_nxt = slip_r;
        rfpu_nxt = 1'b0;
        ifpu_nxt = 1'b0;
        unique case (rx_r)
            pll_ctrl_pkg::rx_idle: begin
                // shift while load is low; msb enters first
                if (sclk_rise && !load_lvl) begin
                    shift_nxt = {shift_r[22:0], sdata_lvl};
                    rx_nxt = pll_ctrl_pkg::rx_shift;
                end
            end
            pll_ctrl_pkg::rx_shift: begin
                if (load_rise) begin
                    rx_nxt = pll_ctrl_pkg::rx_idle;
                    // route by the low control nibble
                    unique case (addr)
                        pll_ctrl_pkg::addr_timeout: begin
                            timeout_nxt = shift_r[pll_ctrl_pkg::timeout_lsb +: pll_ctrl_pkg::timeout_bits];
                        end
                        pll_ctrl_pkg::addr_mode: begin
                            mux_nxt = shift_r[pll_ctrl_pkg::mux_lsb +: 4];
                            osc_nxt = shift_r[pll_ctrl_pkg::osc_lsb];
                            dbl_nxt = shift_r[pll_ctrl_pkg::dbl_lsb];
                            auto_powerup_select_nxt = shift_r[pll_ctrl_pkg::auto_powerup_select_lsb +: 2];
                        end
                        pll_ctrl_pkg::addr_slip: begin
                            slip_nxt = shift_r[pll_ctrl_pkg::slip_lsb +: 2];
                        end
                        pll_ctrl_pkg::addr_main_divider: begin
                            // main word write powers up per code; 3 reserved, no action
                            rfpu_nxt = (auto_powerup_select_r == pll_ctrl_pkg::auto_powerup_select_rf) ||
                                       (auto_powerup_select_r == pll_ctrl_pkg::auto_powerup_select_both);
                            ifpu_nxt = (auto_powerup_select_r == pll_ctrl_pkg::auto_powerup_select_both);
                        end
                        default: begin
                            // aux divider word and others: no auto power-up
                        end
                    endcase
                end else if (sclk_rise && !load_lvl) begin
                    shift_nxt = {shift_r[22:0], sdata_lvl};
                end
            end
            default: rx_nxt = pll_ctrl_pkg::rx_idle;
        endcase
    end

    // register receiver and fields
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_r <= pll_ctrl_pkg::rx_idle;
            shift_r <= 24'h00_0000;
            timeout_r <= pll_ctrl_pkg::timeout_reset;
            mux_r <= pll_ctrl_pkg::mux_reset;
            auto_powerup_select_r <= pll_ctrl_pkg::auto_powerup_select_none;
            osc_r <= 1'b0;
            dbl_r <= 1'b0;
            slip_r <= pll_ctrl_pkg::slip_reset;
            rfpu_r <= 1'b0;
            ifpu_r <= 1'b0;
        end else begin
            rx_r <= rx_nxt;
            shift_r <= shift_nxt;
            timeout_r <= timeout_nxt;
            mux_r <= mux_nxt;
            auto_powerup_select_r <= auto_powerup_select_nxt;
            osc_r <= osc_nxt;
            dbl_r <= dbl_nxt;
            slip_r <= slip_nxt;
            rfpu_r <= rfpu_nxt;
            ifpu_r <= ifpu_nxt;
        end
    end

    // fastlock timer state
    logic [11:0] fl_cnt_r, fl_cnt_nxt; // comparison cycles left
    logic fl_act_r, fl_act_nxt;
    logic auto_en; // timeout in automatic range

    assign auto_en = (timeout_r >= pll_ctrl_pkg::timeout_min_auto);

    // count comparison cycles while in fastlock
    always_comb begin
        fl_cnt_nxt = fl_cnt_r;
        fl_act_nxt = fl_act_r;
        if (!auto_en) begin
            // disabled modes hold the timer idle
            fl_cnt_nxt = 12'h000;
            fl_act_nxt = 1'b0;
        end else if (aux_lock_start) begin
            fl_cnt_nxt = timeout_r;
            fl_act_nxt = 1'b1;
        end else if (fl_act_r && aux_comp_pulse) begin
            // leave after the programmed number of comparisons
            fl_cnt_nxt = fl_cnt_r - 12'h001;
            if (fl_cnt_r == 12'h001) begin
                fl_act_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fl_cnt_r <= 12'h000;
            fl_act_r <= 1'b0;
        end else begin
            fl_cnt_r <= fl_cnt_nxt;
            fl_act_r <= fl_act_nxt;
        end
    end

    // halved divider outputs: toggle on each rising edge
    logic [3:0] div_prev_r, div_prev_nxt;
    logic [3:0] div_half_r, div_half_nxt;
    logic [3:0] div_in;

    assign div_in = {rf_n_out, rf_r_out, if_n_out, if_r_out};

    always_comb begin
        div_prev_nxt = div_in;
        div_half_nxt = div_half_r ^ (div_in & ~div_prev_r);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            div_prev_r <= 4'h0;
            div_half_r <= 4'h0;
        end else begin
            div_prev_r <= div_prev_nxt;
            div_half_r <= div_half_nxt;
        end
    end

    // registered pin and control outputs
    logic fl_o_r, fl_o_nxt, fl_oe_r, fl_oe_nxt;
    logic tl_o_r, tl_o_nxt, tl_oe_r, tl_oe_nxt;
    logic force_r, force_nxt;
    logic [3:0] shiftf_r, shiftf_nxt;

    // aux fastlock pin per timeout value
    always_comb begin
        fl_o_nxt = 1'b0;
        fl_oe_nxt = 1'b1;
        force_nxt = 1'b0;
        unique case (timeout_r)
            12'h000: fl_oe_nxt = 1'b0; // high impedance
            12'h001: begin
                fl_o_nxt = 1'b0; // manual fastlock drives low
                force_nxt = pll_ctrl_pkg::cp_gain_high;
            end
            12'h002: fl_o_nxt = 1'b0;
            12'h003: fl_o_nxt = 1'b1;
            default: fl_o_nxt = fl_act_r; // fastlock indication
        endcase
    end

    // test and lock detect selector
    always_comb begin
        tl_o_nxt = 1'b0;
        tl_oe_nxt = 1'b1;
        unique case (mux_r)
            4'h0: tl_oe_nxt = 1'b0;
            4'h1: tl_o_nxt = 1'b1;
            4'h2: tl_o_nxt = 1'b0;
            4'h3: tl_o_nxt = dig_lock_rf & dig_lock_if;
            4'h4: tl_o_nxt = dig_lock_rf;
            4'h5: tl_o_nxt = dig_lock_if;
            // open drain: drive only the low level
            4'h6: tl_oe_nxt = ~(ana_lock_rf & ana_lock_if);
            4'h7: tl_oe_nxt = ~ana_lock_rf;
            4'h8: tl_oe_nxt = ~ana_lock_if;
            4'h9: tl_o_nxt = ana_lock_rf & ana_lock_if;
            4'ha: tl_o_nxt = ana_lock_rf;
            4'hb: tl_o_nxt = ana_lock_if;
            4'hc: tl_o_nxt = div_half_r[0];
            4'hd: tl_o_nxt = div_half_r[1];
            4'he: tl_o_nxt = div_half_r[2];
            4'hf: tl_o_nxt = div_half_r[3];
        endcase
    end

    // slip reduction factor as a shift: 1, 1/2, 1/4, 1/16
    always_comb begin
        unique case (slip_r)
            2'h0: shiftf_nxt = 4'h0;
            2'h1: shiftf_nxt = 4'h1;
            2'h2: shiftf_nxt = 4'h2;
            2'h3: shiftf_nxt = 4'h4;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fl_o_r <= 1'b0;
            fl_oe_r <= 1'b0;
            tl_o_r <= 1'b0;
            tl_oe_r <= 1'b0;
            force_r <= 1'b0;
            shiftf_r <= 4'h0;
        end else begin
            fl_o_r <= fl_o_nxt;
            fl_oe_r <= fl_oe_nxt;
            tl_o_r <= tl_o_nxt;
            tl_oe_r <= tl_oe_nxt;
            force_r <= force_nxt;
            shiftf_r <= shiftf_nxt;
        end
    end

    assign aux_fastlock_pin_o = fl_o_r;
    assign aux_fastlock_pin_oe = fl_oe_r;
    assign aux_fastlock_active = fl_act_r;
    assign test_lock_pin_o = tl_o_r;
    assign test_lock_pin_oe = tl_oe_r;
    assign aux_pump_gain_force = force_r;
    assign slip_reduction_select = slip_r;
    assign slip_reduction_shift = shiftf_r;
    assign ref_differential_select = osc_r;
    assign ref_doubler_enable = dbl_r;
    assign rf_powerup_pulse = rfpu_r;
    assign if_powerup_pulse = ifpu_r;
endmodule

/* verification/fastlock_ctrl_monitor.sv */
module fastlock_ctrl_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic ser_load,
    input wire logic aux_comp_pulse,
    input wire logic aux_lock_start,
    input wire logic aux_fastlock_pin_o,
    input wire logic aux_fastlock_pin_oe,
    input wire logic aux_fastlock_active,
    input wire logic aux_pump_gain_force,
    input wire logic [1:0] slip_reduction_select,
    input wire logic [3:0] slip_reduction_shift,
    input wire logic rf_powerup_pulse,
    input wire logic if_powerup_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic [3:0] hi_r; // cycles since load went high, saturating
    logic [3:0] hi_nxt;
    logic [3:0] shift_exp; // divisor log2 the stored slip code calls for
    // next value of the load-high counter and the expected shift
    always_comb begin
        hi_nxt = ser_load ? hi_r + ((hi_r != 4'hf) ? 4'h1 : 4'h0) : 4'h0;
        shift_exp = (slip_reduction_select == 2'h3) ? 4'h4 : {2'h0, slip_reduction_select};
    end
    // register only
    always_ff @(posedge clk) begin
        hi_r <= rst ? 4'hf : hi_nxt;
    end
    a_pulse_one_cycle: assert property (rf_powerup_pulse |=> !rf_powerup_pulse)
        else $error("rf power-up pulse held too long");
    a_if_with_rf: assert property (if_powerup_pulse |-> rf_powerup_pulse)
        else $error("aux power-up without main power-up");
    a_pulse_after_load: assert property (rf_powerup_pulse |-> hi_r inside {[1:12]})
        else $error("power-up pulse not tied to a load");
    a_gain_pin_low: assert property (aux_pump_gain_force && $past(aux_pump_gain_force, 2)
        |-> aux_fastlock_pin_oe && !aux_fastlock_pin_o)
        else $error("manual fastlock pin not driven low");
    a_active_pin: assert property (aux_fastlock_active && $past(aux_fastlock_active)
        |-> aux_fastlock_pin_oe && aux_fastlock_pin_o)
        else $error("fastlock pin does not show fastlock");
    a_active_no_gain: assert property (aux_fastlock_active |-> !aux_pump_gain_force)
        else $error("fastlock active with short timeout");
    a_start_cause: assert property ($rose(aux_fastlock_active) |-> $past(aux_lock_start))
        else $error("fastlock started without start pulse");
    a_end_cause: assert property ($fell(aux_fastlock_active) |-> $past(aux_comp_pulse))
        else $error("fastlock ended without comparison");
    a_shift_map: assert property ($stable(slip_reduction_select)
        && slip_reduction_select == $past(slip_reduction_select, 2)
        |-> slip_reduction_shift == shift_exp)
        else $error("slip shift does not match code");
    c_rf_pu: cover property (rf_powerup_pulse);
    c_both_pu: cover property (if_powerup_pulse);
    c_fastlock: cover property ($fell(aux_fastlock_active));
endmodule
bind pll_fastlock_output_control fastlock_ctrl_monitor mon (.*);

/* verification/serial_host.sv */
module serial_host (
    output logic ser_clk,
    output logic ser_data,
    output logic ser_load
);
    timeunit 1ns;
    timeprecision 1ps;
    // link idles with its clock still and load high
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_load = 1'b1;
    end
    // one 24-bit frame, 200 ns per bit
    task automatic send_word(input logic [23:0] w);
        ser_load = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            ser_data = w[i]; // msb first
            #100 ser_clk = 1'b1;
            #100 ser_clk = 1'b0;
        end
        ser_data = ~w[0]; // inverse of the last bit, so a stale sample shows
        #100 ser_load = 1'b1; // load rise latches the word
    endtask
endmodule

/* verification/pll_fastlock_output_control_test.sv */
module pll_fastlock_output_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, chk = 1'b0; // chk: a note waits
    logic aux_lock_start = 1'b0, aux_comp_pulse = 1'b0;
    logic dig_lock_rf = 1'b0, dig_lock_if = 1'b0, ana_lock_rf = 1'b0, ana_lock_if = 1'b0;
    logic [3:0] div = 4'h0; // divider outputs
    wire if_r_out = div[3], if_n_out = div[2], rf_r_out = div[1], rf_n_out = div[0];
    wire ser_clk, ser_data, ser_load;
    logic aux_fastlock_pin_o, aux_fastlock_pin_oe, aux_fastlock_active, test_lock_pin_o, test_lock_pin_oe;
    logic aux_pump_gain_force, ref_differential_select, ref_doubler_enable, rf_powerup_pulse, if_powerup_pulse;
    logic [1:0] slip_reduction_select;
    logic [3:0] slip_reduction_shift;
    int fail_count = 0, compares = 0;
    logic [31:0] xs = 32'h0e9a_1776; // random state
    logic [51:0] notes[$]; // {mask, expected}
    logic [51:0] note;
    logic [3:0] n_rise = 4'h0, n_rf = 4'h0, n_if = 4'h0; // events since last check
    logic tpo_d = 1'b0;
    logic [1:0] slip_m = 2'h0, pu_m = 2'h0; // expected stored fields
    logic [11:0] tmo_m = 12'h000;
    logic [3:0] mux_m = 4'h0;
    logic diff_m = 1'b0, dbl_m = 1'b0;
    wire [25:0] obs = {n_rise, n_rf, n_if, aux_fastlock_pin_o, aux_fastlock_pin_oe, aux_fastlock_active,
        test_lock_pin_o, test_lock_pin_oe, aux_pump_gain_force, slip_reduction_select, slip_reduction_shift,
        ref_differential_select, ref_doubler_enable};
    always #12.5 clk = ~clk;
    serial_host host (.*);
    pll_fastlock_output_control uut (.*);
    function automatic logic [31:0] rnd();
        xs ^= xs << 13;
        xs ^= xs >> 17;
        xs ^= xs << 5;
        return xs;
    endfunction
    // test pin {o known, o, oe}
    function automatic logic [2:0] tl_exp();
        logic s;
        s = (mux_m inside {4'h6, 4'h9}) ? ana_lock_rf & ana_lock_if : (mux_m inside {4'h7, 4'ha}) ? ana_lock_rf
            : ana_lock_if;
        case (mux_m)
            4'h0: return 3'b000; // released
            4'h1, 4'h2: return {1'b1, ~mux_m[1], 1'b1}; // forced level
            4'h3: return {1'b1, dig_lock_rf & dig_lock_if, 1'b1};
            4'h4: return {1'b1, dig_lock_rf, 1'b1};
            4'h5: return {1'b1, dig_lock_if, 1'b1};
            4'h6, 4'h7, 4'h8: return {~s, 1'b0, ~s}; // open drain
            4'h9, 4'ha, 4'hb: return {1'b1, s, 1'b1};
            default: return 3'b001; // halved divider, level judged by edge count
        endcase
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // note what the outputs must show now and ask for a compare
    task automatic check(input logic a, input logic [11:0] cnt, input logic r);
        logic [2:0] t;
        logic [1:0] ap;
        t = tl_exp();
        ap = (tmo_m == 12'h0) ? 2'b00 : (tmo_m == 12'h3) ? 2'b11 : (tmo_m > 12'h3) ? {a, 1'b1} : 2'b01;
        notes.push_back({{4{r}}, 8'hff, tmo_m != 12'h0, 2'b11, t[2], 10'h3ff, cnt, ap, a, t[1:0],
            tmo_m == 12'h1, slip_m, (slip_m == 2'h3) ? 4'h4 : {2'h0, slip_m}, diff_m, dbl_m});
        chk = 1'b1;
        tick(1);
        chk = 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [19:0] d);
        host.send_word({d, a});
        tick(10);
    endtask
    task automatic pulse_cmp();
        aux_comp_pulse = 1'b1;
        tick(1);
        aux_comp_pulse = 1'b0;
        tick(1);
    endtask
    // one fastlock period of t comparisons
    task automatic fl(input logic [11:0] t);
        tmo_m = t;
        wr(pll_ctrl_pkg::addr_timeout, {8'h00, t});
        check(1'b0, 12'h000, 1'b0);
        aux_lock_start = 1'b1;
        tick(1);
        aux_lock_start = 1'b0;
        for (int i = 1; i < t; i++) pulse_cmp();
        tick(3);
        check(1'b1, 12'h000, 1'b0);
        pulse_cmp();
        tick(3);
        check(1'b0, 12'h000, 1'b0);
    endtask
    task automatic end_sim();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // oldest note against the outputs
    always @(posedge clk) begin
        if (chk) begin
            note = notes.pop_front();
            compares++;
            if ((obs & note[51:26]) !== (note[25:0] & note[51:26])) begin
                fail_count++;
                $display("[ERR] %0t exp %h got %h", $time, note[25:0] & note[51:26], obs & note[51:26]);
            end
            {n_rise, n_rf, n_if} = 12'h000;
        end else if (!rst) begin
            // outputs are unknown before the first reset edge, so count only once out of reset
            n_rise += 4'(test_lock_pin_o & ~tpo_d);
            n_rf += 4'(rf_powerup_pulse);
            n_if += 4'(if_powerup_pulse);
        end
        tpo_d = test_lock_pin_o;
    end
    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        end_sim();
    end
    initial begin
        tick(6);
        rst = 1'b0;
        tick(4);
        check(1'b0, 12'h000, 1'b0);
        for (int c = 0; c < 4; c++) begin // every bandwidth ratio band
            slip_m = 2'(c);
            wr(pll_ctrl_pkg::addr_slip, {slip_m, 18'h0});
            check(1'b0, 12'h000, 1'b0);
        end
        for (int c = 0; c < 4; c++) begin
            {pu_m, dbl_m, diff_m} = {2'(c), 2'(c)};
            wr(pll_ctrl_pkg::addr_mode, {12'h000, pu_m, dbl_m, diff_m, mux_m});
            check(1'b0, 12'h000, 1'b0);
            wr(pll_ctrl_pkg::addr_main_divider, 20'(rnd()));
            check(1'b0, {4'h0, 4'(c == 1 || c == 2), 4'(c == 2)}, 1'b0);
            wr(pll_ctrl_pkg::addr_aux_divider, 20'(rnd()));
            check(1'b0, 12'h000, 1'b0);
        end
        wr(4'hf, 20'(rnd()));
        check(1'b0, 12'h000, 1'b0);
        for (int c = 0; c < 4; c++) begin
            tmo_m = 12'(c);
            wr(pll_ctrl_pkg::addr_timeout, {8'h00, tmo_m});
            aux_lock_start = 1'b1;
            tick(1);
            aux_lock_start = 1'b0;
            tick(3);
            check(1'b0, 12'h000, 1'b0);
        end
        fl(12'h004);
        fl(12'(5 + rnd() % 40));
        fl(12'hfff);
        for (int c = 0; c < 16; c++) begin
            mux_m = 4'(c);
            wr(pll_ctrl_pkg::addr_mode, {12'h000, pu_m, dbl_m, diff_m, mux_m});
            {dig_lock_rf, dig_lock_if, ana_lock_rf, ana_lock_if} = 4'(rnd());
            tick(3);
            check(1'b0, 12'h000, 1'b0);
            if (c > 11) begin
                repeat (8) begin
                    div[15 - c] = 1'b1;
                    tick(2);
                    div[15 - c] = 1'b0;
                    tick(2);
                end
                tick(3);
                check(1'b0, 12'h400, 1'b1);
            end
        end
        tick(2);
        end_sim();
    end
endmodule
